/* osts_defs.vh */
`ifndef OSTS_DEFS_VH
`define OSTS_DEFS_VH
// Command codes
`define OSTS_CMD_CLEAR     8'h03
`define OSTS_CMD_SLEW      8'h27
`define OSTS_CMD_OTF       8'h4F
`define OSTS_CMD_OTW       8'h51
`define OSTS_CMD_UTF       8'h53
`define OSTS_CMD_RISE_LIM  8'h62
`define OSTS_CMD_OFF_DLY   8'h64
`define OSTS_CMD_FALL      8'h65
`define OSTS_CMD_OFF_WARN  8'h66
`define OSTS_CMD_SBYTE     8'h78
`define OSTS_CMD_SWORD     8'h79
`define OSTS_CMD_SVOUT     8'h7A
`define OSTS_CMD_SIOUT     8'h7B
`define OSTS_CMD_SINPUT    8'h7C
`define OSTS_CMD_STEMP     8'h7D
`define OSTS_CMD_SCML      8'h7E
`define OSTS_CMD_SVEND     8'h80
`define OSTS_CMD_INFO      8'hB6
`define OSTS_CMD_PADS      8'hE5
`define OSTS_CMD_GENERIC   8'hEF
`define OSTS_CMD_SLOPE     8'hF8
`define OSTS_CMD_OFFSET    8'hF9
// Reset values
`define OSTS_RST_OTF       16'hEB20
`define OSTS_RST_OTW       16'hEAA8
`define OSTS_RST_UTF       16'hE580
`define OSTS_RST_SLOPE     16'h4000
`define OSTS_RST_OFFSET    16'h8000
`define OSTS_RST_RISE_LIM  16'hD280
`define OSTS_RST_SLEW      16'hAA00
`define OSTS_RST_OFF_DLY   16'h8000
`define OSTS_RST_FALL      16'hD200
`define OSTS_RST_OFF_WARN  16'hF258
// Status bit positions
`define OSTS_SV_RISE_FLT   2
`define OSTS_SV_OFF_WARN   1
`define OSTS_ST_OTF        7
`define OSTS_ST_OTW        6
`define OSTS_ST_UTF        4
`define OSTS_CML_BADCMD    7
// Valid clear masks
`define OSTS_SV_MASK       8'hFE
`define OSTS_ST_MASK       8'hD0
// Timing
`define OSTS_CLK_NS        32'h00000019
`define OSTS_TICK_NS       32'h0003D090
`define OSTS_TICK_CYC      (`OSTS_TICK_NS / `OSTS_CLK_NS)
`define OSTS_TICKS_PER_MS  (32'h000F4240 / `OSTS_TICK_NS)
`define OSTS_RISE_MAX_MS   32'h00001F40
`define OSTS_OFF_DLY_MAX_MS 32'h00003E80
`define OSTS_FALL_MAX_MS   32'h00000514
`define OSTS_SLEW_MIN_MV   32'h00000001
`define OSTS_SLEW_MAX_MV   32'h00000FA0
`endif

/* osts_seq_temp_status.v */
`timescale 1ns/1ps
`include "osts_defs.vh"
// Behaviour
// - Rise timeout fault if UV not crossed
// - Zero disables rise timeout; eight seconds maximum
// - Slew applies only to setpoint changes
// - Slew at least 1mV/ms; above 4V/ms step
// - Wait turn-off delay, up to sixteen seconds
// - Fall ramps command linearly to zero
// - PWM disabled at end of fall
// - Conduction mode frozen during fall
// - Short or steep fall uses 0.25ms; 1.3s max
// - Off-time warning if decay too slow
// - Off warning disabled by zero or config
// - Temperature offset in volts when mode set
// - Above overtemp fault limit sets fault
// - Overtemp warning sets bits and alert
// - Below undertemp fault limit sets fault
// - Status byte and word per channel
// - Clear-all command clears every fault bit
// - Clear, input, CML, generic status, pads and maker info shared; rest paged
// - Pads, generic status, maker info read-only
// - Write one clears individual status bit
// - Times decoded from exponent-mantissa words
module osts_seq_temp_status #(
	parameter integer TICK_CYC   = `OSTS_TICK_CYC,
	parameter integer DEG_PER_V  = 100,
	parameter [15:0]  MAKER_INFO = 16'h5A5A
) (
	// Clock and reset
	input  wire        ref_clk,
	input  wire        resetn,
	// Command port from serial engine
	input  wire        cmd_valid,
	input  wire        cmd_write,
	input  wire [7:0]  cmd_code,
	input  wire [15:0] cmd_wdata,
	input  wire        page_sel,
	output reg         rsp_valid,
	output reg  [15:0] rsp_data,
	output reg         rsp_err,
	// Asynchronous pins
	input  wire [1:0]  run_pin,
	input  wire [1:0]  vout_above_uv,
	input  wire [1:0]  vout_below_off,
	input  wire [15:0] pad_state,
	// Settings from core logic
	input  wire [25:0] vout_setpoint,
	input  wire [31:0] ext_temp_raw,
	input  wire [1:0]  cfg_off_warn_dis,
	input  wire [1:0]  cfg_offset_volts,
	input  wire [1:0]  cfg_ccm,
	input  wire [1:0]  alert_mask_otw,
	input  wire [7:0]  generic_status_in,
	// Power stage control
	output wire [1:0]  pwm_en,
	output wire [1:0]  pwm_ccm,
	output wire [25:0] vout_cmd,
	// Alert pin
	output reg         alert_out,
	output reg         alert_oe_n
);

localparam integer MS_CYC     = TICK_CYC * `OSTS_TICKS_PER_MS;
localparam integer RISE_MAX_Q = `OSTS_RISE_MAX_MS * `OSTS_TICKS_PER_MS;
localparam integer DLY_MAX_Q  = `OSTS_OFF_DLY_MAX_MS * `OSTS_TICKS_PER_MS;
localparam integer FALL_MAX_Q = `OSTS_FALL_MAX_MS * `OSTS_TICKS_PER_MS;
localparam integer FALL_MV_Q  = `OSTS_SLEW_MAX_MV / `OSTS_TICKS_PER_MS;
localparam [5:0] S_OFF  = 6'h01;
localparam [5:0] S_RISE = 6'h02;
localparam [5:0] S_ON   = 6'h04;
localparam [5:0] S_DLY  = 6'h08;
localparam [5:0] S_FALL = 6'h10;
localparam [5:0] S_DEC  = 6'h20;

// Exponent-mantissa word scaled by two to the sh
function signed [47:0] l11q;
	input [15:0] v;
	input [4:0]  sh;
	reg signed [47:0] m;
	reg signed [6:0]  e;
	begin
		m = {{37{v[10]}}, v[10:0]};
		e = $signed({{2{v[15]}}, v[15:11]}) + $signed({2'b00, sh});
		if (e[6]) begin
			l11q = m >>> (-e);
		end else begin
			l11q = m <<< e;
		end
	end
endfunction

// Time word to quarter-ms ticks, negative as zero
function [23:0] tq;
	input [15:0] v;
	reg signed [47:0] x;
	begin
		x = l11q(v, 5'h02);
		if (x < 0) begin
			tq = 24'h0;
		end else if (x > 48'sh0000FFFFFF) begin
			tq = 24'hFFFFFF;
		end else begin
			tq = x[23:0];
		end
	end
endfunction

reg        rs1;
reg        rst_n;
reg [1:0]  run_m;
reg [1:0]  run_s;
reg [1:0]  run_d;
reg [1:0]  uv_m;
reg [1:0]  uv_s;
reg [1:0]  off_m;
reg [1:0]  off_s;
reg [15:0] pad_m;
reg [15:0] pad_s;
reg [31:0] tick_cnt;
reg        tick;
reg [7:0]  cml;
reg [15:0] sh_rd;
reg        sh_hit;
reg        sh_ro;
wire [31:0] ch_rd;
wire [1:0]  ch_hit;
wire [1:0]  ch_alert;

// Reset released through two flops
always @(posedge ref_clk or negedge resetn) begin
	if (!resetn) begin
		rs1   <= 1'b0;
		rst_n <= 1'b0;
	end else begin
		rs1   <= 1'b1;
		rst_n <= rs1;
	end
end

always @(posedge ref_clk or negedge rst_n) begin
	if (!rst_n) begin
		run_m <= 2'h0;
		run_s <= 2'h0;
		run_d <= 2'h0;
		uv_m  <= 2'h0;
		uv_s  <= 2'h0;
		off_m <= 2'h0;
		off_s <= 2'h0;
		pad_m <= 16'h0;
		pad_s <= 16'h0;
	end else begin
		run_m <= run_pin;
		run_s <= run_m;
		run_d <= run_s;
		uv_m  <= vout_above_uv;
		uv_s  <= uv_m;
		off_m <= vout_below_off;
		off_s <= off_m;
		pad_m <= pad_state;
		pad_s <= pad_m;
	end
end

// One tick each quarter millisecond
always @(posedge ref_clk or negedge rst_n) begin
	if (!rst_n) begin
		tick_cnt <= 32'h0;
		tick     <= 1'b0;
	end else if (tick_cnt >= TICK_CYC - 1) begin
		tick_cnt <= 32'h0;
		tick     <= 1'b1;
	end else begin
		tick_cnt <= tick_cnt + 32'h1;
		tick     <= 1'b0;
	end
end

wire clr_all = cmd_valid & cmd_write & (cmd_code == `OSTS_CMD_CLEAR);
wire [15:0] sel_rd  = page_sel ? ch_rd[31:16] : ch_rd[15:0];
wire        sel_hit = page_sel ? ch_hit[1] : ch_hit[0];
wire        bad     = cmd_valid & (~(sh_hit | sel_hit) | (cmd_write & sh_ro));

// Unpaged commands
always @* begin
	sh_rd  = 16'h0;
	sh_hit = 1'b1;
	sh_ro  = 1'b0;
	case (cmd_code)
		`OSTS_CMD_CLEAR: begin
			sh_hit = cmd_write;
		end
		`OSTS_CMD_SINPUT: begin
			sh_rd = 16'h0;
		end
		`OSTS_CMD_SCML: begin
			sh_rd = {8'h0, cml};
		end
		`OSTS_CMD_PADS: begin
			sh_rd = pad_s;
			sh_ro = 1'b1;
		end
		`OSTS_CMD_GENERIC: begin
			sh_rd = {8'h0, generic_status_in};
			sh_ro = 1'b1;
		end
		`OSTS_CMD_INFO: begin
			sh_rd = MAKER_INFO;
			sh_ro = 1'b1;
		end
		default: begin
			sh_hit = 1'b0;
		end
	endcase
end

// Set wins over clear on the shared byte
wire [7:0] cml_clr = clr_all ? 8'hFF :
	(cmd_valid & cmd_write & (cmd_code == `OSTS_CMD_SCML)) ? cmd_wdata[7:0] : 8'h0;

always @(posedge ref_clk or negedge rst_n) begin
	if (!rst_n) begin
		cml        <= 8'h0;
		rsp_valid  <= 1'b0;
		rsp_data   <= 16'h0;
		rsp_err    <= 1'b0;
		alert_out  <= 1'b0;
		alert_oe_n <= 1'b1;
	end else begin
		cml        <= (cml & ~cml_clr) | (bad ? (8'h1 << `OSTS_CML_BADCMD) : 8'h0);
		rsp_valid  <= cmd_valid;
		rsp_data   <= (cmd_valid & ~cmd_write) ? (sh_hit ? sh_rd : sel_rd) : 16'h0;
		rsp_err    <= bad;
		alert_out  <= 1'b0;
		alert_oe_n <= ~((|ch_alert) | (|cml));
	end
end

genvar g;
generate
	for (g = 0; g < 2; g = g + 1) begin : chan
		reg [15:0] otf;
		reg [15:0] otw;
		reg [15:0] utf;
		reg [15:0] slope;
		reg [15:0] offs;
		reg [15:0] rlim;
		reg [15:0] slew;
		reg [15:0] tdly;
		reg [15:0] tfall;
		reg [15:0] twarn;
		reg [5:0]  st;
		reg [23:0] cnt;
		reg [39:0] acc;
		reg [12:0] vc;
		reg        pwm;
		reg        ccm;
		reg        rise_ev;
		reg        warn_ev;
		reg [7:0]  svout;
		reg [7:0]  stemp;
		reg [15:0] rd;
		reg        hit;
		wire        pg    = (g == 1) ? 1'b1 : 1'b0;
		wire        wr    = cmd_valid & cmd_write & (page_sel == pg);
		wire [12:0] sp    = vout_setpoint[g*13 +: 13];
		wire        start = run_s[g] & ~run_d[g];
		wire        stop  = ~run_s[g] & run_d[g];
		// Temperature in sixteenths of a degree
		wire signed [47:0] raw  = {{32{ext_temp_raw[g*16+15]}}, ext_temp_raw[g*16 +: 16]};
		wire signed [47:0] sl   = {{32{slope[15]}}, slope};
		wire signed [47:0] offq = l11q(offs, 5'h04);
		wire signed [47:0] offc = cfg_offset_volts[g] ? offq * DEG_PER_V : offq;
		wire signed [47:0] tsen = ((raw * sl) >>> 14) + offc;
		wire ot_f = tsen > l11q(otf, 5'h04);
		wire ot_w = tsen > l11q(otw, 5'h04);
		wire ut_f = tsen < l11q(utf, 5'h04);
		// Sequencing limits
		wire [23:0] rq    = tq(rlim);
		wire [23:0] r_lim = (rq > RISE_MAX_Q) ? RISE_MAX_Q[23:0] : rq;
		wire [23:0] dq    = tq(tdly);
		wire [23:0] d_lim = (dq > DLY_MAX_Q) ? DLY_MAX_Q[23:0] : dq;
		wire [23:0] fqr   = tq(tfall);
		wire        steep = {23'h0, sp} > ({12'h0, fqr} * FALL_MV_Q);
		wire [23:0] f_lim = (fqr == 24'h0 || steep) ? 24'h1 :
			((fqr > FALL_MAX_Q) ? FALL_MAX_Q[23:0] : fqr);
		wire [39:0] f_cyc = {16'h0, f_lim} * TICK_CYC;
		wire [23:0] w_lim = tq(twarn);
		wire        w_off = (w_lim == 24'h0) | cfg_off_warn_dis[g];
		// Slew rate in mV per ms
		wire signed [47:0] rate_x = (l11q(slew, 5'h0A) * 48'sh3E8) >>> 10;
		wire [12:0] rate = (rate_x < `OSTS_SLEW_MIN_MV) ? 13'h1 : rate_x[12:0];
		wire        slew_step = rate_x > `OSTS_SLEW_MAX_MV;
		wire [7:0] clr_v = clr_all ? `OSTS_SV_MASK :
			(wr & (cmd_code == `OSTS_CMD_SVOUT)) ? (cmd_wdata[7:0] & `OSTS_SV_MASK) : 8'h0;
		wire [7:0] clr_t = clr_all ? `OSTS_ST_MASK :
			(wr & (cmd_code == `OSTS_CMD_STEMP)) ? (cmd_wdata[7:0] & `OSTS_ST_MASK) : 8'h0;
		wire [7:0] sbyte = {1'b0, ~pwm, 3'h0, |stemp, |cml, 1'b0};
		wire [7:0] shigh = {|svout[7:1], 3'h0, (st != S_ON), 3'h0};

		assign pwm_en[g]           = pwm;
		assign pwm_ccm[g]          = ccm;
		assign vout_cmd[g*13 +: 13] = vc;
		assign ch_rd[g*16 +: 16]   = rd;
		assign ch_hit[g]           = hit;
		assign ch_alert[g]         = (|svout) | (|(stemp & {1'b1, ~alert_mask_otw[g], 6'h3F}));

		always @* begin
			rd  = 16'h0;
			hit = 1'b1;
			case (cmd_code)
				`OSTS_CMD_OTF:      rd = otf;
				`OSTS_CMD_OTW:      rd = otw;
				`OSTS_CMD_UTF:      rd = utf;
				`OSTS_CMD_SLOPE:    rd = slope;
				`OSTS_CMD_OFFSET:   rd = offs;
				`OSTS_CMD_RISE_LIM: rd = rlim;
				`OSTS_CMD_SLEW:     rd = slew;
				`OSTS_CMD_OFF_DLY:  rd = tdly;
				`OSTS_CMD_FALL:     rd = tfall;
				`OSTS_CMD_OFF_WARN: rd = twarn;
				`OSTS_CMD_SBYTE:    rd = {8'h0, sbyte};
				`OSTS_CMD_SWORD:    rd = {shigh, sbyte};
				`OSTS_CMD_SVOUT:    rd = {8'h0, svout};
				`OSTS_CMD_SIOUT:    rd = 16'h0;
				`OSTS_CMD_STEMP:    rd = {8'h0, stemp};
				`OSTS_CMD_SVEND:    rd = 16'h0;
				default:            hit = 1'b0;
			endcase
		end

		always @(posedge ref_clk or negedge rst_n) begin
			if (!rst_n) begin
				otf   <= `OSTS_RST_OTF;
				otw   <= `OSTS_RST_OTW;
				utf   <= `OSTS_RST_UTF;
				slope <= `OSTS_RST_SLOPE;
				offs  <= `OSTS_RST_OFFSET;
				rlim  <= `OSTS_RST_RISE_LIM;
				slew  <= `OSTS_RST_SLEW;
				tdly  <= `OSTS_RST_OFF_DLY;
				tfall <= `OSTS_RST_FALL;
				twarn <= `OSTS_RST_OFF_WARN;
			end else if (wr) begin
				case (cmd_code)
					`OSTS_CMD_OTF:      otf   <= cmd_wdata;
					`OSTS_CMD_OTW:      otw   <= cmd_wdata;
					`OSTS_CMD_UTF:      utf   <= cmd_wdata;
					`OSTS_CMD_SLOPE:    slope <= cmd_wdata;
					`OSTS_CMD_OFFSET:   offs  <= cmd_wdata;
					`OSTS_CMD_RISE_LIM: rlim  <= cmd_wdata;
					`OSTS_CMD_SLEW:     slew  <= cmd_wdata;
					`OSTS_CMD_OFF_DLY:  tdly  <= cmd_wdata;
					`OSTS_CMD_FALL:     tfall <= cmd_wdata;
					`OSTS_CMD_OFF_WARN: twarn <= cmd_wdata;
					default: begin
					end
				endcase
			end
		end

		// Sticky status, set wins over clear
		always @(posedge ref_clk or negedge rst_n) begin
			if (!rst_n) begin
				svout <= 8'h0;
				stemp <= 8'h0;
			end else begin
				svout <= (svout & ~clr_v) | {5'h0, rise_ev, warn_ev, 1'b0};
				stemp <= (stemp & ~clr_t) | {ot_f, ot_w, 1'b0, ut_f, 4'h0};
			end
		end

		always @(posedge ref_clk or negedge rst_n) begin
			if (!rst_n) begin
				st      <= S_OFF;
				cnt     <= 24'h0;
				acc     <= 40'h0;
				vc      <= 13'h0;
				pwm     <= 1'b0;
				ccm     <= 1'b0;
				rise_ev <= 1'b0;
				warn_ev <= 1'b0;
			end else begin
				rise_ev <= 1'b0;
				warn_ev <= 1'b0;
				if (st != S_FALL) begin
					ccm <= cfg_ccm[g];
				end
				case (st)
					S_OFF: begin
						if (start) begin
							st  <= S_RISE;
							cnt <= 24'h0;
							pwm <= 1'b1;
							vc  <= sp;
						end
					end
					S_RISE: begin
						vc <= sp;
						if (stop) begin
							st  <= S_DLY;
							cnt <= 24'h0;
						end else if (uv_s[g]) begin
							st  <= S_ON;
							acc <= 40'h0;
						end else if (r_lim != 24'h0 && cnt >= r_lim) begin
							st      <= S_OFF;
							rise_ev <= 1'b1;
							pwm     <= 1'b0;
							vc      <= 13'h0;
						end else if (tick) begin
							cnt <= cnt + 24'h1;
						end
					end
					S_ON: begin
						if (stop) begin
							st  <= S_DLY;
							cnt <= 24'h0;
						end else if (vc == sp) begin
							acc <= 40'h0;
						end else if (slew_step) begin
							vc <= sp;
						end else if (acc + {27'h0, rate} >= MS_CYC) begin
							acc <= acc + {27'h0, rate} - MS_CYC;
							vc  <= (vc < sp) ? vc + 13'h1 : vc - 13'h1;
						end else begin
							acc <= acc + {27'h0, rate};
						end
					end
					S_DLY: begin
						if (start) begin
							st  <= S_RISE;
							cnt <= 24'h0;
						end else if (cnt >= d_lim) begin
							st  <= S_FALL;
							cnt <= 24'h0;
							acc <= 40'h0;
						end else if (tick) begin
							cnt <= cnt + 24'h1;
						end
					end
					S_FALL: begin
						// Needs setpoint no more than f_cyc, the clocks in the whole fall
						if (cnt >= f_lim) begin
							vc  <= 13'h0;
							pwm <= 1'b0;
							cnt <= 24'h0;
							st  <= w_off ? S_OFF : S_DEC;
						end else begin
							if (tick) begin
								cnt <= cnt + 24'h1;
							end
							if (acc + {27'h0, sp} >= f_cyc) begin
								acc <= acc + {27'h0, sp} - f_cyc;
								vc  <= (vc != 13'h0) ? vc - 13'h1 : vc;
							end else begin
								acc <= acc + {27'h0, sp};
							end
						end
					end
					S_DEC: begin
						if (start) begin
							st  <= S_RISE;
							cnt <= 24'h0;
							pwm <= 1'b1;
							vc  <= sp;
						end else if (off_s[g]) begin
							st <= S_OFF;
						end else if (cnt >= w_lim) begin
							st      <= S_OFF;
							warn_ev <= 1'b1;
						end else if (tick) begin
							cnt <= cnt + 24'h1;
						end
					end
					default: begin
						st  <= S_OFF;
						pwm <= 1'b0;
					end
				endcase
			end
		end
	end
endgenerate

endmodule // osts_seq_temp_status

/* osts_host_model.sv */
`timescale 1ns/1ps
module osts_host_model (
	// Clock
	input  wire        ref_clk,
	// Command side
	output reg         cmd_valid,
	output reg         cmd_write,
	output reg  [7:0]  cmd_code,
	output reg  [15:0] cmd_wdata,
	output reg         page_sel,
	// Answer side
	input  wire        rsp_valid,
	input  wire [15:0] rsp_data,
	input  wire        rsp_err
);
	initial begin
		cmd_valid = 1'b0;
		cmd_write = 1'b0;
		cmd_code  = 8'h00;
		cmd_wdata = 16'h0000;
		page_sel  = 1'b0;
	end
	// One command a call; answer taken at the next falling edge
	task xfer(input w, input [7:0] c, input [15:0] d, input pg, output [15:0] q, output e, output ok);
		begin
			@(negedge ref_clk);
			cmd_valid = 1'b1;
			cmd_write = w;
			cmd_code  = c;
			cmd_wdata = w ? d : ~cmd_wdata;
			page_sel  = pg;
			@(negedge ref_clk);
			q         = rsp_data;
			e         = rsp_err;
			ok        = rsp_valid;
			cmd_valid = 1'b0;
			// Released lines must not look held
			cmd_wdata = ~cmd_wdata;
			cmd_code  = ~cmd_code;
		end
	endtask
endmodule // osts_host_model

/* osts_chk_properties.sv */
`timescale 1ns/1ps
module osts_chk #(
	parameter [15:0] MAKER_INFO = 16'h5A5A
) (
	// Clock and reset
	input wire        ref_clk,
	input wire        resetn,
	// Command port
	input wire        cmd_valid,
	input wire        cmd_write,
	input wire [7:0]  cmd_code,
	input wire        page_sel,
	input wire        rsp_valid,
	input wire [15:0] rsp_data,
	input wire        rsp_err,
	// Outputs
	input wire [1:0]  pwm_en,
	input wire        alert_out
);
	reg  exp_off;
	wire rd = cmd_valid && !cmd_write;
	wire ro = cmd_code == 8'hE5 || cmd_code == 8'hEF || cmd_code == 8'hB6;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	// Paged channel off flag at the taking edge
	always @(posedge ref_clk)
		exp_off <= page_sel ? ~pwm_en[1] : ~pwm_en[0];
	rsp_follows_cmd_a: assert property (cmd_valid |=> rsp_valid)
		else $error("no answer");
	rsp_only_cmd_a: assert property (!cmd_valid |=> !rsp_valid && !rsp_err)
		else $error("stray answer");
	ro_write_err_a: assert property (cmd_valid && cmd_write && ro |=> rsp_err)
		else $error("read-only write accepted");
	clear_read_err_a: assert property (rd && cmd_code == 8'h03 |=> rsp_err)
		else $error("clear read accepted");
	clear_write_ok_a: assert property (cmd_valid && cmd_write && cmd_code == 8'h03 |=> !rsp_err)
		else $error("clear refused");
	info_read_a: assert property (rd && cmd_code == 8'hB6 |=> rsp_data == MAKER_INFO && !rsp_err)
		else $error("info word wrong");
	status_byte_a: assert property (rd && cmd_code == 8'h78 |=> rsp_data[15:8] == 8'h00 && rsp_data[6] == exp_off)
		else $error("status byte wrong");
	alert_data_a: assert property (alert_out == 1'b0 ##1 alert_out == 1'b0)
		else $error("alert data high");
endmodule // osts_chk
bind osts_seq_temp_status osts_chk #(.MAKER_INFO(MAKER_INFO)) chk (
	.ref_clk(ref_clk),
	.resetn(resetn),
	.cmd_valid(cmd_valid),
	.cmd_write(cmd_write),
	.cmd_code(cmd_code),
	.page_sel(page_sel),
	.rsp_valid(rsp_valid),
	.rsp_data(rsp_data),
	.rsp_err(rsp_err),
	.pwm_en(pwm_en),
	.alert_out(alert_out)
);

/* tb.sv */
`timescale 1ns/1ps
`define CHK(n, x, g) begin total_checks = total_checks + 1; if ((g) !== (x)) begin \
	bad_count = bad_count + 1; $display("FAIL %s exp %h got %h", n, x, g); end end
module tb;
	// Arbitrary value
	localparam [15:0] INFO = 16'h3C3C;
	reg         ref_clk, resetn;
	reg  [1:0]  run_pin, vout_above_uv, vout_below_off, cfg_off_warn_dis;
	reg  [1:0]  cfg_offset_volts, cfg_ccm, alert_mask_otw;
	reg  [15:0] pad_state, q, d;
	reg  [25:0] vout_setpoint;
	reg  [31:0] ext_temp_raw;
	reg  [7:0]  generic_status_in;
	reg  [23:0] t;
	reg         e, ok;
	integer     bad_count, total_checks, seed, i;
	wire        cmd_valid, cmd_write, page_sel, rsp_valid, rsp_err, alert_out, alert_oe_n;
	wire [7:0]  cmd_code;
	wire [15:0] cmd_wdata, rsp_data;
	wire [1:0]  pwm_en, pwm_ccm;
	wire [25:0] vout_cmd;
	osts_host_model host (.ref_clk(ref_clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
		.cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .page_sel(page_sel),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_err(rsp_err));
	// Short tick keeps the off-time wait inside the run
	osts_seq_temp_status #(.TICK_CYC(10), .MAKER_INFO(INFO)) uut (.ref_clk(ref_clk), .resetn(resetn),
		.cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
		.page_sel(page_sel), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_err(rsp_err),
		.run_pin(run_pin), .vout_above_uv(vout_above_uv), .vout_below_off(vout_below_off),
		.pad_state(pad_state), .vout_setpoint(vout_setpoint), .ext_temp_raw(ext_temp_raw),
		.cfg_off_warn_dis(cfg_off_warn_dis), .cfg_offset_volts(cfg_offset_volts), .cfg_ccm(cfg_ccm),
		.alert_mask_otw(alert_mask_otw), .generic_status_in(generic_status_in), .pwm_en(pwm_en),
		.pwm_ccm(pwm_ccm), .vout_cmd(vout_cmd), .alert_out(alert_out), .alert_oe_n(alert_oe_n));
	initial ref_clk = 1'b0;
	always #12.5 ref_clk = ~ref_clk;
	function [23:0] tab(input integer k);
		case (k)
			0: tab = {8'h4F, 16'hEB20};
			1: tab = {8'h51, 16'hEAA8};
			2: tab = {8'h53, 16'hE580};
			3: tab = {8'hF8, 16'h4000};
			default: tab = {8'hF9, 16'h8000};
		endcase
	endfunction
	task end_of_test;
		begin
			$display("checks %0d mismatches %0d", total_checks, bad_count);
			if (bad_count == 0 && total_checks > 0)
				$display("Finished cleanly");
			else
				$display("Finished with errors");
			$finish;
		end
	endtask
	task wt(input integer n);
		repeat (n) @(negedge ref_clk);
	endtask
	task cmd(input w, input [7:0] c, input [15:0] dd, input pg);
		host.xfer(w, c, dd, pg, q, e, ok);
		`CHK("answer", 1'b1, ok)
	endtask
	task rd(input [7:0] c, input pg, input [15:0] x);
		cmd(1'b0, c, 16'h0000, pg);
		`CHK($sformatf("read %h", c), x, q)
		`CHK("read error", 1'b0, e)
	endtask
	task wr(input [7:0] c, input pg, input [15:0] dd, input xe);
		cmd(1'b1, c, dd, pg);
		`CHK($sformatf("error %h", c), xe, e)
	endtask
	// Hang guard
	initial begin
		#(25 * 40000);
		bad_count = bad_count + 1;
		$display("FAIL watchdog exp done got hang");
		end_of_test;
	end
	initial begin
		seed = 32'h953a;
		bad_count = 0;
		total_checks = 0;
		resetn = 1'b0;
		{run_pin, vout_above_uv, vout_below_off, cfg_off_warn_dis, cfg_offset_volts, alert_mask_otw} = 12'h000;
		cfg_ccm = 2'b01;
		pad_state = $random(seed);
		generic_status_in = $random(seed);
		vout_setpoint = {13'd50, 13'd100};
		ext_temp_raw = {16'h0190, 16'h0190};
		wt(12);
		resetn = 1'b1;
		wt(4);
		for (i = 0; i < 5; i = i + 1) begin
			t = tab(i);
			rd(t[23:16], 1'b0, t[15:0]);
			d = $random(seed);
			wr(t[23:16], i[0], d, 1'b0);
			rd(t[23:16], i[0], d);
			wr(t[23:16], i[0], t[15:0], 1'b0);
		end
		wr(8'h03, 1'b0, 16'h0000, 1'b0);
		wr(8'hE5, 1'b0, 16'hFFFF, 1'b1);
		wr(8'hEF, 1'b1, 16'hFFFF, 1'b1);
		wr(8'hB6, 1'b0, 16'hFFFF, 1'b1);
		rd(8'hE5, 1'b0, pad_state);
		rd(8'hEF, 1'b0, {8'h00, generic_status_in});
		rd(8'hB6, 1'b0, INFO);
		rd(8'h7E, 1'b1, 16'h0080);
		rd(8'h78, 1'b1, 16'h0042);
		rd(8'h79, 1'b0, 16'h0842);
		`CHK("alert", 1'b0, alert_oe_n)
		wr(8'h7E, 1'b0, 16'h0080, 1'b0);
		rd(8'h7E, 1'b0, 16'h0000);
		wr(8'h11, 1'b0, 16'h0000, 1'b1);
		cmd(1'b0, 8'h03, 16'h0000, 1'b0);
		`CHK("clear read", 1'b1, e)
		wr(8'h03, 1'b1, 16'h0000, 1'b0);
		rd(8'h78, 1'b0, 16'h0040);
		`CHK("alert", 1'b1, alert_oe_n)
		ext_temp_raw = {16'h0190, 16'h06E0};
		wt(10);
		rd(8'h7D, 1'b0, 16'h00C0);
		rd(8'h7D, 1'b1, 16'h0000);
		rd(8'h78, 1'b0, 16'h0044);
		`CHK("alert", 1'b0, alert_oe_n)
		ext_temp_raw = {16'hFCE0, 16'h0190};
		wt(10);
		wr(8'h7D, 1'b0, 16'h00D0, 1'b0);
		rd(8'h7D, 1'b0, 16'h0000);
		rd(8'h7D, 1'b1, 16'h0010);
		ext_temp_raw = {16'h0190, 16'h05A0};
		alert_mask_otw = 2'b01;
		wr(8'h03, 1'b0, 16'h0000, 1'b0);
		wt(10);
		rd(8'h7D, 1'b0, 16'h0040);
		`CHK("masked alert", 1'b1, alert_oe_n)
		ext_temp_raw = {16'h0190, 16'h0190};
		wr(8'h03, 1'b0, 16'h0000, 1'b0);
		run_pin = 2'b01;
		wt(10);
		`CHK("rise pwm", 1'b1, pwm_en[0])
		`CHK("rise cmd", 13'd100, vout_cmd[12:0])
		wt(480);
		rd(8'h7A, 1'b0, 16'h0004);
		`CHK("timeout pwm", 1'b0, pwm_en[0])
		run_pin = 2'b00;
		wr(8'h03, 1'b0, 16'h0000, 1'b0);
		wr(8'h62, 1'b1, 16'h0000, 1'b0);
		run_pin = 2'b10;
		wt(600);
		`CHK("no limit pwm", 1'b1, pwm_en[1])
		rd(8'h7A, 1'b1, 16'h0000);
		vout_above_uv = 2'b11;
		run_pin = 2'b11;
		wt(20);
		rd(8'h79, 1'b0, 16'h0000);
		// Zero rate must still move at the 1 mV per ms floor
		wr(8'h27, 1'b0, 16'hB000, 1'b0);
		vout_setpoint = {13'd50, 13'd110};
		wt(100);
		`CHK("slew slow", 1'b1, vout_cmd[12:0] > 13'd100 && vout_cmd[12:0] < 13'd104)
		wt(1900);
		`CHK("slew end", 13'd110, vout_cmd[12:0])
		cfg_off_warn_dis = 2'b10;
		run_pin = 2'b00;
		wt(160);
		`CHK("fall pwm", 1'b1, pwm_en[0])
		`CHK("fall mid", 1'b1, vout_cmd[12:0] > 13'd0 && vout_cmd[12:0] < 13'd110)
		cfg_ccm = 2'b10;
		wt(2);
		`CHK("fall mode", 1'b1, pwm_ccm[0])
		wt(200);
		`CHK("fall end pwm", 2'b00, pwm_en)
		`CHK("fall end cmd", 13'd0, vout_cmd[12:0])
		wt(6100);
		rd(8'h7A, 1'b0, 16'h0002);
		rd(8'h7A, 1'b1, 16'h0000);
		rd(8'h79, 1'b0, 16'h8840);
		end_of_test;
	end
endmodule // tb
